// ### rtl/mgmt_regs_pkg.sv
package mgmt_regs_pkg;

	localparam int NUM_REG = 13;
	localparam int ADDR_W  = 5;
	localparam int DATA_W  = 16;
	localparam int IDX_W   = 4;

	typedef logic [ADDR_W-1:0] addr_t;
	typedef logic [DATA_W-1:0] word_t;
	typedef logic [IDX_W-1:0]  idx_t;

	localparam word_t UNMAPPED_READ = 16'hFFFF;

	// Identifier contents; the values are arbitrary.
	localparam word_t ID_HIGH_VALUE = 16'hA5A5;
	localparam word_t ID_LOW_VALUE  = 16'h5A50;

	// Register addresses on the management link.
	localparam addr_t ADR_BASIC_CONTROL   = 5'h00;
	localparam addr_t ADR_BASIC_STATUS    = 5'h01;
	localparam addr_t ADR_ID_HIGH         = 5'h02;
	localparam addr_t ADR_ID_LOW          = 5'h03;
	localparam addr_t ADR_NEG_ADVERTISE   = 5'h04;
	localparam addr_t ADR_PARTNER_ABILITY = 5'h05;
	localparam addr_t ADR_NEG_EXPANSION   = 5'h06;
	localparam addr_t ADR_NEXT_PAGE_TX    = 5'h07;
	localparam addr_t ADR_PARTNER_NP      = 5'h08;
	localparam addr_t ADR_EXT_CONTROL     = 5'h10;
	localparam addr_t ADR_STATUS_POLL     = 5'h11;
	localparam addr_t ADR_TEN_MBIT_OPS    = 5'h12;
	localparam addr_t ADR_EXT_CONTROL_2   = 5'h13;

	// Storage slots of the implemented registers.
	localparam idx_t IDX_CONTROL   = 4'h0;
	localparam idx_t IDX_STATUS    = 4'h1;
	localparam idx_t IDX_ID_HIGH   = 4'h2;
	localparam idx_t IDX_ADVERTISE = 4'h4;
	localparam idx_t IDX_NP_TX     = 4'h7;
	localparam idx_t IDX_EXT_CTRL  = 4'h9;
	localparam idx_t IDX_TEN_MBIT  = 4'hB;

	localparam addr_t SLOT_ADDR [NUM_REG] = '{
		ADR_BASIC_CONTROL, ADR_BASIC_STATUS, ADR_ID_HIGH, ADR_ID_LOW,
		ADR_NEG_ADVERTISE, ADR_PARTNER_ABILITY, ADR_NEG_EXPANSION,
		ADR_NEXT_PAGE_TX, ADR_PARTNER_NP, ADR_EXT_CONTROL,
		ADR_STATUS_POLL, ADR_TEN_MBIT_OPS, ADR_EXT_CONTROL_2};

	// Bit positions.
	localparam int OVERRIDE_BIT  = 15;
	localparam int PREAMBLE_BIT  = 6;
	localparam int ISOLATE_BIT   = 10;
	localparam int PHYAD_LSB     = 6;
	localparam int EXT_W0_BIT    = 1;

	// Per-slot access masks and defaults, slot 0 first.
	localparam word_t RW_MASK [NUM_REG] = '{
		16'hFF80, 16'h0000, 16'h0000, 16'h0000, 16'hFFE0, 16'h0000,
		16'h0000, 16'hFFFF, 16'h0000, 16'h783C, 16'h0000, 16'h00FE,
		16'h00FF};
	localparam word_t OW_MASK [NUM_REG] = '{
		16'h0000, 16'h0040, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000};
	localparam word_t W0_MASK [NUM_REG] = '{
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0001,
		16'h0000};
	localparam word_t LIVE_MASK [NUM_REG] = '{
		16'h0000, 16'hFFBF, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF,
		16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000,
		16'h0000};
	localparam word_t STRAP_MASK [NUM_REG] = '{
		16'h0400, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h07C0, 16'h0000, 16'h0000,
		16'h0000};
	localparam word_t DEF_VAL [NUM_REG] = '{
		16'h3000, 16'h0000, ID_HIGH_VALUE, ID_LOW_VALUE, 16'h01E1,
		16'h0000, 16'h0000, 16'h2001, 16'h0000, 16'h0002, 16'h0000,
		16'h0001, 16'h0000};

endpackage

// ### rtl/mgmt_reg_cell.sv
`timescale 1ns/100ps
`default_nettype none

// One 16-bit management register with per-bit access types.
module mgmt_reg_cell #(
	parameter logic [15:0] DEF   = 16'h0000,
	parameter logic [15:0] RW_M  = 16'h0000,
	parameter logic [15:0] OW_M  = 16'h0000,
	parameter logic [15:0] W0_M  = 16'h0000,
	parameter logic [15:0] LIV_M = 16'h0000,
	parameter logic [15:0] STR_M = 16'h0000
) (
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_wr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_ovr,
	input  wire logic        i_strap_ld,
	input  wire logic [15:0] i_strap_val,
	input  wire logic [15:0] i_live,
	output logic      [15:0] o_value
);
	logic [15:0] stored_q;
	logic [15:0] stored_d;
	logic [15:0] ow_en;

	// Each bit follows its own access type within one write.
	always_comb begin
		ow_en    = i_ovr ? OW_M : 16'h0000;
		stored_d = stored_q;
		if (i_wr) begin
			stored_d = (stored_q & ~(RW_M | ow_en | W0_M))
				| (i_wdata & (RW_M | ow_en))
				| (stored_q & i_wdata & W0_M);
		end
		if (i_strap_ld) begin
			stored_d = (stored_d & ~STR_M) | (i_strap_val & STR_M);
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			stored_q <= DEF;
		end else begin
			stored_q <= stored_d;
		end
	end

	// Bits without a default come straight from their source logic.
	assign o_value = (stored_q & ~LIV_M) | (i_live & LIV_M);

endmodule

`default_nettype wire

// ### rtl/mgmt_reg_bank.sv
`timescale 1ns/100ps
`default_nettype none

module mgmt_reg_bank (
	input  wire logic                   I_CLK,
	input  wire logic                   I_ARST_N,
	input  wire mgmt_regs_pkg::addr_t   I_REG_ADDR,
	input  wire logic                   I_WR_STB,
	input  wire mgmt_regs_pkg::word_t   I_WR_DATA,
	input  wire logic                   I_RD_STB,
	output mgmt_regs_pkg::word_t        O_RD_DATA,
	output logic                        O_RD_VALID,
	input  wire mgmt_regs_pkg::addr_t   I_STRAP_ADDR,
	input  wire logic [13*16-1:0]       I_LIVE_BITS,
	output mgmt_regs_pkg::word_t        O_CONTROL,
	output mgmt_regs_pkg::word_t        O_EXT_CONTROL,
	output mgmt_regs_pkg::word_t        O_TEN_MBIT_OPS,
	output logic                        O_OVERRIDE_ARMED,
	output logic                        O_PREAMBLE_SUPPRESS,
	output mgmt_regs_pkg::addr_t        O_PHY_ADDR
);
	import mgmt_regs_pkg::*;

	logic [NUM_REG-1:0][15:0] reg_val;
	logic [NUM_REG-1:0]       wr_sel;
	logic                     ovr_q;
	logic                     strap_done_q;
	logic                     strap_ld;
	word_t                    rd_q;
	logic                     rd_vld_q;
	logic                     hit;
	idx_t                     idx;
	word_t                    rd_word;
	word_t                    strap_iso;
	word_t                    strap_phy;

	// Looks up the storage slot of a link address; MSB flags a hit.
	function automatic logic [IDX_W:0] find_slot(input addr_t a);
		logic [IDX_W:0] r;
		r = '0;
		for (int k = 0; k < NUM_REG; k++) begin
			if (SLOT_ADDR[k] == a) begin
				r = {1'b1, IDX_W'(k)};
			end
		end
		return r;
	endfunction

	assign {hit, idx} = find_slot(I_REG_ADDR);

	always_comb begin
		for (int k = 0; k < NUM_REG; k++) begin
			wr_sel[k] = I_WR_STB && hit && (idx == IDX_W'(k));
		end
	end

	// Strap levels are caught on the first edge after reset release.
	assign strap_ld = !strap_done_q;

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			strap_done_q <= 1'b0;
		end else begin
			strap_done_q <= 1'b1;
		end
	end

	always_comb begin
		strap_iso = '0;
		strap_iso[ISOLATE_BIT] = (I_STRAP_ADDR == '0);
		strap_phy = '0;
		strap_phy[PHYAD_LSB +: ADDR_W] = I_STRAP_ADDR;
	end

	// Override-enable: armed by a write of one, spent by the next write.
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ovr_q <= 1'b0;
		end else if (I_WR_STB) begin
			ovr_q <= wr_sel[IDX_EXT_CTRL]
				&& I_WR_DATA[OVERRIDE_BIT];
		end
	end

	generate
		for (genvar g = 0; g < NUM_REG; g++) begin : g_reg
			mgmt_reg_cell #(
				.DEF   (DEF_VAL[g]),
				.RW_M  (RW_MASK[g]),
				.OW_M  (OW_MASK[g]),
				.W0_M  (W0_MASK[g]),
				.LIV_M (LIVE_MASK[g]),
				.STR_M (STRAP_MASK[g])
			) u_cell (
				.i_clk       (I_CLK),
				.i_arst_n    (I_ARST_N),
				.i_wr        (wr_sel[g]),
				.i_wdata     (I_WR_DATA),
				.i_ovr       (ovr_q),
				.i_strap_ld  (strap_ld),
				.i_strap_val (g == IDX_CONTROL ? strap_iso : strap_phy),
				.i_live      (I_LIVE_BITS[g*DATA_W +: DATA_W]),
				.o_value     (reg_val[g])
			);
		end
	endgenerate

	always_comb begin
		rd_word = UNMAPPED_READ;
		if (hit) begin
			rd_word = reg_val[idx];
			if (idx == IDX_EXT_CTRL) begin
				rd_word[OVERRIDE_BIT] = ovr_q;
			end
		end
	end

	// Read answer is held until the next read strobe.
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rd_q <= '0;
		end else if (I_RD_STB) begin
			rd_q <= rd_word;
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rd_vld_q <= 1'b0;
		end else begin
			rd_vld_q <= I_RD_STB;
		end
	end

	assign O_RD_DATA           = rd_q;
	assign O_RD_VALID          = rd_vld_q;
	assign O_CONTROL           = reg_val[IDX_CONTROL];
	assign O_EXT_CONTROL       = reg_val[IDX_EXT_CTRL];
	assign O_TEN_MBIT_OPS      = reg_val[IDX_TEN_MBIT];
	assign O_OVERRIDE_ARMED    = ovr_q;
	assign O_PREAMBLE_SUPPRESS = reg_val[IDX_STATUS][PREAMBLE_BIT];
	assign O_PHY_ADDR          = reg_val[IDX_EXT_CTRL][PHYAD_LSB +: ADDR_W];

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_ARST_N);

	property p_read_only_kept;
		(I_WR_STB && hit && idx == IDX_ADVERTISE)
		|=> reg_val[IDX_ADVERTISE][4:0]
			== $past(reg_val[IDX_ADVERTISE][4:0]);
	endproperty
	a_read_only_kept: assert property (p_read_only_kept)
		else $error("read-only bits changed on write");

	property p_ow_blocked;
		(wr_sel[IDX_STATUS] && !ovr_q)
		|=> $stable(reg_val[IDX_STATUS][PREAMBLE_BIT]);
	endproperty
	a_ow_blocked: assert property (p_ow_blocked)
		else $error("gated bit written without override");

	property p_ow_allowed;
		(wr_sel[IDX_STATUS] && ovr_q)
		|=> reg_val[IDX_STATUS][PREAMBLE_BIT]
			== $past(I_WR_DATA[PREAMBLE_BIT]);
	endproperty
	a_ow_allowed: assert property (p_ow_allowed)
		else $error("gated bit not written under override");

	property p_ovr_once;
		(ovr_q && I_WR_STB
			&& !(wr_sel[IDX_EXT_CTRL] && I_WR_DATA[OVERRIDE_BIT]))
		|=> !ovr_q [*2] or (!ovr_q ##1 ovr_q);
	endproperty
	a_ovr_once: assert property (p_ovr_once)
		else $error("override not cleared by next write");

	property p_ovr_arm;
		(wr_sel[IDX_EXT_CTRL] && I_WR_DATA[OVERRIDE_BIT])
		|=> ovr_q && O_RD_DATA == $past(O_RD_DATA, 1)
			|| ovr_q && $past(I_RD_STB);
	endproperty
	a_ovr_arm: assert property (p_ovr_arm)
		else $error("override not armed by write of one");

	property p_rw_store;
		wr_sel[IDX_CONTROL]
		|=> (reg_val[IDX_CONTROL] & RW_MASK[IDX_CONTROL])
			== ($past(I_WR_DATA) & RW_MASK[IDX_CONTROL]);
	endproperty
	a_rw_store: assert property (p_rw_store)
		else $error("read/write bits did not store data");

	property p_w0_only;
		wr_sel[IDX_EXT_CTRL]
		|=> reg_val[IDX_EXT_CTRL][EXT_W0_BIT]
			== ($past(reg_val[IDX_EXT_CTRL][EXT_W0_BIT])
				& $past(I_WR_DATA[EXT_W0_BIT]));
	endproperty
	a_w0_only: assert property (p_w0_only)
		else $error("write-zero-only bit took a one");

	property p_reset_default;
		@(posedge I_CLK) (I_ARST_N && !strap_done_q)
		|-> reg_val[IDX_NP_TX] == DEF_VAL[IDX_NP_TX]
			&& ovr_q == 1'b0;
	endproperty
	a_reset_default: assert property (p_reset_default)
		else $error("default not loaded by reset");

	property p_strap_capture;
		strap_ld
		|=> O_PHY_ADDR == $past(I_STRAP_ADDR)
			&& O_CONTROL[ISOLATE_BIT] == ($past(I_STRAP_ADDR) == '0);
	endproperty
	a_strap_capture: assert property (p_strap_capture)
		else $error("strap levels not captured");

	property p_unmapped_read;
		(I_RD_STB && !hit) |=> O_RD_VALID && O_RD_DATA == UNMAPPED_READ;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read did not return all ones");

	property p_unmapped_write;
		(I_WR_STB && !hit && !strap_ld) |=> $stable(reg_val[IDX_CONTROL])
			&& $stable(reg_val[IDX_TEN_MBIT]);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write)
		else $error("unmapped write changed a register");

	property p_live_bits;
		(reg_val[IDX_STATUS] & LIVE_MASK[IDX_STATUS])
		== (I_LIVE_BITS[IDX_STATUS*DATA_W +: DATA_W]
			& LIVE_MASK[IDX_STATUS]);
	endproperty
	a_live_bits: assert property (p_live_bits)
		else $error("live bits do not follow their source");

	property p_read_mapped;
		(I_RD_STB && hit && idx == IDX_TEN_MBIT)
		|=> O_RD_DATA == $past(reg_val[IDX_TEN_MBIT]);
	endproperty
	a_read_mapped: assert property (p_read_mapped)
		else $error("mapped read returned wrong word");

	property p_live_read;
		(I_RD_STB && hit && idx == IDX_STATUS)
		|=> (O_RD_DATA & LIVE_MASK[IDX_STATUS])
			== ($past(I_LIVE_BITS[IDX_STATUS*DATA_W +: DATA_W])
				& LIVE_MASK[IDX_STATUS]);
	endproperty
	a_live_read: assert property (p_live_read)
		else $error("read of live bits returned a stale value");

	property p_map_hit;
		hit == (I_REG_ADDR <= ADR_PARTNER_NP
			|| (I_REG_ADDR >= ADR_EXT_CONTROL
				&& I_REG_ADDR <= ADR_EXT_CONTROL_2));
	endproperty
	a_map_hit: assert property (p_map_hit)
		else $error("address decode disagrees with the map");

	property p_rd_valid;
		(I_RD_STB |=> O_RD_VALID) and (!I_RD_STB |=> !O_RD_VALID);
	endproperty
	a_rd_valid: assert property (p_rd_valid)
		else $error("read answer strobe out of step");

	property p_rd_hold;
		!I_RD_STB |=> $stable(O_RD_DATA);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read answer changed without a read");

	property p_reset_values;
		(I_ARST_N && !strap_done_q)
		|-> O_TEN_MBIT_OPS == DEF_VAL[IDX_TEN_MBIT]
			&& (O_CONTROL & ~STRAP_MASK[IDX_CONTROL])
			== (DEF_VAL[IDX_CONTROL] & ~STRAP_MASK[IDX_CONTROL]);
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("register left reset without its default");

	property p_mixed_write;
		(wr_sel[IDX_EXT_CTRL] && !strap_ld)
		|=> (O_EXT_CONTROL & RW_MASK[IDX_EXT_CTRL])
			== ($past(I_WR_DATA) & RW_MASK[IDX_EXT_CTRL])
			&& $stable(O_PHY_ADDR);
	endproperty
	a_mixed_write: assert property (p_mixed_write)
		else $error("mixed write broke a bit's own rule");

	c_override_write: cover property (
		wr_sel[IDX_EXT_CTRL] && I_WR_DATA[OVERRIDE_BIT]
		##[1:8] wr_sel[IDX_STATUS] && ovr_q);
	c_unmapped_read: cover property (I_RD_STB && !hit);
	c_w0_clear: cover property (
		wr_sel[IDX_EXT_CTRL] && !I_WR_DATA[EXT_W0_BIT]);
	c_blocked_write: cover property (wr_sel[IDX_STATUS] && !ovr_q);

endmodule

`default_nettype wire

// ### dv/station_manager.sv
`timescale 1ns/100ps
`default_nettype none

// Station manager: issues register accesses, one per cycle at most.
module station_manager (
	input  wire logic                  i_clk,
	output var mgmt_regs_pkg::addr_t   o_addr,
	output var logic                   o_wr,
	output var mgmt_regs_pkg::word_t   o_wdata,
	output var logic                   o_rd
);
	import mgmt_regs_pkg::*;

	initial begin
		o_addr = '0;
		o_wr = 1'b0;
		o_wdata = '0;
		o_rd = 1'b0;
	end

	// Callers hand over whole words, which are driven as given, reserved bits included.
	task automatic access(input logic w, input logic r, input addr_t a,
		input word_t d);
		@(negedge i_clk);
		o_wr = w;
		o_rd = r;
		o_addr = a;
		o_wdata = d;
	endtask

	// Idle address and data lines show the inverse of the last value, so two releases in a row bring back a stale copy.
	task automatic release_bus();
		@(negedge i_clk);
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = ~o_addr;
		o_wdata = ~o_wdata;
	endtask
endmodule

`default_nettype wire

// ### dv/phy_mgmt_register_access_test.sv
`timescale 1ns/100ps
`default_nettype none

module phy_mgmt_register_access_test;
	import mgmt_regs_pkg::*;

	logic           i_clk;
	logic           i_arst_n;
	addr_t          reg_addr;
	logic           wr_stb;
	word_t          wr_data;
	logic           rd_stb;
	word_t          rd_data;
	logic           rd_valid;
	addr_t          strap;
	logic [207:0]   live;
	word_t          control;
	word_t          ext_control;
	word_t          ten_ops;
	logic           armed;
	logic           preamble;
	addr_t          phy_addr;
	int             error_cnt;
	int             checks;
	int             cyc;
	int             seed;
	word_t          st [NUM_REG];
	logic           arm;
	word_t          exp_q [$];

	mgmt_reg_bank mgmt_reg_bank_i (
		.I_CLK(i_clk), .I_ARST_N(i_arst_n), .I_REG_ADDR(reg_addr),
		.I_WR_STB(wr_stb), .I_WR_DATA(wr_data), .I_RD_STB(rd_stb),
		.O_RD_DATA(rd_data), .O_RD_VALID(rd_valid),
		.I_STRAP_ADDR(strap), .I_LIVE_BITS(live), .O_CONTROL(control),
		.O_EXT_CONTROL(ext_control), .O_TEN_MBIT_OPS(ten_ops),
		.O_OVERRIDE_ARMED(armed), .O_PREAMBLE_SUPPRESS(preamble),
		.O_PHY_ADDR(phy_addr));

	station_manager station_manager_i (
		.i_clk(i_clk), .o_addr(reg_addr), .o_wr(wr_stb),
		.o_wdata(wr_data), .o_rd(rd_stb));

	always #4 i_clk = ~i_clk;

	task automatic finish_test();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge i_clk) begin
		cyc++;
		if (cyc >= 20000) begin
			error_cnt++;
			$display("FAIL %0t run did not finish", $time);
			finish_test();
		end
	end

	task automatic check(input word_t seen, input word_t exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic int slot_of(input addr_t a);
		for (int k = 0; k < NUM_REG; k++)
			if (SLOT_ADDR[k] === a)
				return k;
		return -1;
	endfunction

	function automatic word_t view(input int k);
		word_t v;
		v = (st[k] & ~LIVE_MASK[k]) | (live[k*16+:16] & LIVE_MASK[k]);
		return (k == 9) ? (v | {arm, 15'h0000}) : v;
	endfunction

	// Expected read words are queued here and retired by the watcher.
	always @(negedge i_clk) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				error_cnt++;
				$display("FAIL %0t read answer not requested", $time);
			end else
				check(rd_data, exp_q.pop_front());
		end
	end

	task automatic wr(input addr_t a, input word_t d);
		int k;
		k = slot_of(a);
		station_manager_i.access(1'b1, 1'b0, a, d);
		if (k >= 0) begin
			st[k] = (st[k] & ~RW_MASK[k]) | (d & RW_MASK[k]);
			st[k] &= ~(W0_MASK[k] & ~d);
			if (arm)
				st[k] = (st[k] & ~OW_MASK[k]) | (d & OW_MASK[k]);
		end
		arm = (k == 9) && d[OVERRIDE_BIT];
		if ($random(seed) % 2)
			station_manager_i.release_bus();
	endtask

	task automatic rd(input addr_t a);
		int k;
		k = slot_of(a);
		exp_q.push_back((k >= 0) ? view(k) : UNMAPPED_READ);
		station_manager_i.access(1'b0, 1'b1, a, 16'h0000);
		if ($random(seed) % 2)
			station_manager_i.release_bus();
	endtask

	task automatic read_all();
		for (int a = 0; a < 32; a++)
			rd(addr_t'(a));
	endtask

	task automatic outs();
		station_manager_i.release_bus();
		check(control, st[0]);
		check(ext_control, st[9]);
		check(ten_ops, st[11]);
		check({15'h0000, armed}, {15'h0000, arm});
		check({15'h0000, preamble}, {15'h0000, st[1][PREAMBLE_BIT]});
		check({11'h000, phy_addr}, {11'h000, strap});
	endtask

	task automatic end_test(input string name);
		repeat (3) @(negedge i_clk);
		check(word_t'(exp_q.size()), 16'h0000);
		$display("test %s done, errors %0d", name, error_cnt);
	endtask

	task automatic do_reset(input addr_t s);
		@(negedge i_clk);
		i_arst_n = 1'b0;
		strap = s;
		for (int k = 0; k < NUM_REG; k++)
			live[k*16+:16] = word_t'($random(seed));
		repeat (8) @(negedge i_clk);
		i_arst_n = 1'b1;
		for (int k = 0; k < NUM_REG; k++)
			st[k] = DEF_VAL[k];
		st[0][ISOLATE_BIT] = (s == 5'h00);
		st[9][PHYAD_LSB+:5] = s;
		arm = 1'b0;
	endtask

	initial begin
		i_clk = 1'b0;
		i_arst_n = 1'b0;
		strap = 5'h00;
		live = '0;
		error_cnt = 0;
		checks = 0;
		cyc = 0;
		seed = 32'hA922E714;
		arm = 1'b0;
		do_reset(addr_t'($random(seed)) | 5'h01);
		read_all();
		outs();
		end_test("defaults");
		repeat (3) begin
			for (int a = 0; a < 32; a++)
				wr(addr_t'(a), word_t'($random(seed)));
			read_all();
			outs();
		end
		end_test("random writes");
		wr(ADR_EXT_CONTROL, st[9] | 16'h8000);
		wr(ADR_BASIC_STATUS, 16'h0000);
		wr(ADR_BASIC_STATUS, 16'h0040);
		outs();
		wr(ADR_EXT_CONTROL, st[9] | 16'h8000);
		outs();
		rd(ADR_EXT_CONTROL);
		wr(ADR_BASIC_STATUS, 16'h0040);
		outs();
		wr(ADR_BASIC_STATUS, 16'h0000);
		wr(ADR_EXT_CONTROL, st[9] | 16'h8000);
		wr(5'h1F, 16'h0000);
		wr(ADR_BASIC_STATUS, 16'h0000);
		outs();
		wr(ADR_TEN_MBIT_OPS, 16'hFFFF);
		wr(ADR_TEN_MBIT_OPS, 16'h0000);
		wr(ADR_TEN_MBIT_OPS, 16'hFFFF);
		read_all();
		outs();
		end_test("override and write-zero");
		do_reset(5'h00);
		read_all();
		outs();
		end_test("second reset");
		finish_test();
	end
endmodule

`default_nettype wire
